// [rtl/bvs_blank_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module bvs_blank_timer
  import bvs_pkg::*;
#(
  parameter int BLANK_CYCLES = BVS_BLANK_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic start,
  output logic      blanking
);

  typedef struct packed {
    logic [BVS_BLANK_W-1:0] count;
    logic                   busy;
  } bvs_timer_state_t;

  localparam logic [BVS_BLANK_W-1:0] LAST = BVS_BLANK_W'(BLANK_CYCLES - 1);

  bvs_timer_state_t state;
  bvs_timer_state_t next_state;

  // A fresh write restarts the interval, so blanking runs 5 ms past the last write
  always_comb begin
    next_state = state;
    if (start) begin
      next_state.count = '0;
      next_state.busy  = 1'b1;
    end else if (state.busy) begin
      if (state.count == LAST) begin
        next_state.busy = 1'b0;
      end else begin
        next_state.count = state.count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign blanking = state.busy;

endmodule : bvs_blank_timer
`default_nettype wire

// [rtl/bvs_pkg.sv]
package bvs_pkg;

  // Register subaddresses on the serial host interface
  localparam logic [7:0] BVS_OFS_BUCK_ONE = 8'h16;
  localparam logic [7:0] BVS_OFS_BUCK_TWO = 8'h17;
  localparam logic [7:0] BVS_OFS_APPLY    = 8'h1A;

  // Field layout of a converter setting register
  localparam int BVS_SKIP_BIT  = 7;
  localparam int BVS_RSVD_BIT  = 6;
  localparam int BVS_CODE_MSB  = 5;
  localparam int BVS_CODE_LSB  = 0;

  // Reset values
  localparam logic [7:0] BVS_SETTING_RST = 8'h99;
  localparam logic [5:0] BVS_CODE_RST    = 6'h19;
  localparam logic       BVS_SKIP_RST    = 1'b1;
  localparam logic [10:0] BVS_MV_RST     = 11'h44C;  // 1100 mV for code 19h
  localparam logic [7:0]  BVS_RDATA_RST  = 8'h00;

  // Voltage map: millivolt base, fine step up to the knee code, coarse step above
  localparam logic [5:0]  BVS_CODE_KNEE    = 6'h32;
  localparam logic [10:0] BVS_MV_BASE      = 11'h352;  // 850 mV
  localparam logic [10:0] BVS_MV_FINE_STEP = 11'h00A;  // 10 mV
  localparam logic [10:0] BVS_MV_COARSE    = 11'h019;  // 25 mV

  // Monitor blanking after a setting write
  localparam int          BVS_CLK_MHZ      = 250;
  localparam int          BVS_BLANK_MS     = 5;
  localparam int          BVS_BLANK_CYCLES = BVS_BLANK_MS * 1000 * BVS_CLK_MHZ;
  localparam int          BVS_BLANK_W      = 21;

  // One converter's setting as it travels through the block
  typedef struct packed {
    logic       skip_en;
    logic [5:0] code;
  } bvs_setting_t;

  // Host write strobe with its address and data
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } bvs_wreq_t;

endpackage : bvs_pkg

// [rtl/bvs_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module bvs_regs
  import bvs_pkg::*;
#(
  parameter int BLANK_CYCLES = BVS_BLANK_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire bvs_wreq_t  host_wreq,
  input  wire logic [7:0] host_raddr,
  input  wire logic       unlocked,
  input  wire logic       apply_go,
  input  wire logic       apply_bypass,
  output logic [7:0]      host_rdata,
  output logic            buck_one_skip_en,
  output logic [5:0]      buck_one_code,
  output logic [10:0]     buck_one_mv,
  output logic            buck_two_skip_en,
  output logic [5:0]      buck_two_code,
  output logic [10:0]     buck_two_mv,
  output logic            monitor_blank
);

  typedef struct packed {
    bvs_setting_t one_reg;
    bvs_setting_t two_reg;
    bvs_setting_t one_out;
    bvs_setting_t two_out;
    logic [10:0]  one_mv;
    logic [10:0]  two_mv;
    logic [7:0]   rdata;
    logic         blank;
  } bvs_state_t;

  localparam bvs_setting_t SET_RST = '{skip_en: BVS_SKIP_RST, code: BVS_CODE_RST};

  bvs_state_t state;
  bvs_state_t next_state;
  logic       wr_one;
  logic       wr_two;
  logic       timer_blank;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Code to millivolts: 10 mV steps to the knee, 25 mV above it
  function automatic logic [10:0] bvs_code_mv(input logic [5:0] code);
    logic [10:0] fine;
    logic [10:0] coarse;
    fine   = 11'(code) * BVS_MV_FINE_STEP;
    coarse = 11'(code - BVS_CODE_KNEE) * BVS_MV_COARSE;
    if (code <= BVS_CODE_KNEE) begin
      bvs_code_mv = BVS_MV_BASE + fine;
    end else begin
      bvs_code_mv = BVS_MV_BASE + 11'(BVS_CODE_KNEE) * BVS_MV_FINE_STEP + coarse;
    end
  endfunction : bvs_code_mv

  // Register byte view: reserved bit 6 always zero
  function automatic logic [7:0] bvs_pack(input bvs_setting_t s);
    bvs_pack = {s.skip_en, 1'b0, s.code};
  endfunction : bvs_pack

  ////////////////////////////////////////////////////////////////////////////
  // Write decode

  // Locked writes are dropped silently, no error reported
  assign wr_one = host_wreq.wr && unlocked && (host_wreq.addr == BVS_OFS_BUCK_ONE);
  assign wr_two = host_wreq.wr && unlocked && (host_wreq.addr == BVS_OFS_BUCK_TWO);

  bvs_blank_timer #(
    .BLANK_CYCLES (BLANK_CYCLES)
  ) u_blank (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .start    (wr_one || wr_two),
    .blanking (timer_blank)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_state = state;
    // Stored settings take the host byte, bit 6 discarded
    if (wr_one) begin
      next_state.one_reg.skip_en = host_wreq.data[BVS_SKIP_BIT];
      next_state.one_reg.code    = host_wreq.data[BVS_CODE_MSB:BVS_CODE_LSB];
    end
    if (wr_two) begin
      next_state.two_reg.skip_en = host_wreq.data[BVS_SKIP_BIT];
      next_state.two_reg.code    = host_wreq.data[BVS_CODE_MSB:BVS_CODE_LSB];
    end
    // Skip mode follows the register at once; voltage waits for apply
    next_state.one_out.skip_en = next_state.one_reg.skip_en;
    next_state.two_out.skip_en = next_state.two_reg.skip_en;
    if (apply_go || apply_bypass) begin
      next_state.one_out.code = state.one_reg.code;
      next_state.two_out.code = state.two_reg.code;
    end
    next_state.one_mv = bvs_code_mv(next_state.one_out.code);
    next_state.two_mv = bvs_code_mv(next_state.two_out.code);
    // Read mux registered: data valid one cycle after the address
    unique case (host_raddr)
      BVS_OFS_BUCK_ONE: next_state.rdata = bvs_pack(state.one_reg);
      BVS_OFS_BUCK_TWO: next_state.rdata = bvs_pack(state.two_reg);
      default:          next_state.rdata = 8'h00;
    endcase
    next_state.blank = timer_blank || wr_one || wr_two;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state.one_reg <= SET_RST;
      state.two_reg <= SET_RST;
      state.one_out <= SET_RST;
      state.two_out <= SET_RST;
      state.one_mv  <= BVS_MV_RST;  // Matches the reset code, no map needed here
      state.two_mv  <= BVS_MV_RST;
      state.rdata   <= BVS_RDATA_RST;
      state.blank   <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign host_rdata       = state.rdata;
  assign buck_one_skip_en = state.one_out.skip_en;
  assign buck_one_code    = state.one_out.code;
  assign buck_one_mv      = state.one_mv;
  assign buck_two_skip_en = state.two_out.skip_en;
  assign buck_two_code    = state.two_out.code;
  assign buck_two_mv      = state.two_mv;
  assign monitor_blank    = state.blank;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_locked_write;
    host_wreq.wr && !unlocked;
  endsequence

  property p_reset_value;
    @(posedge clk_sys) $fell(rst) |-> (bvs_pack(state.two_reg) == BVS_SETTING_RST);
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("setting reset value wrong");

  property p_locked_ignored;
    @(posedge clk_sys) disable iff (rst)
      s_locked_write |=> $stable(state.one_reg) && $stable(state.two_reg);
  endproperty
  a_locked_ignored: assert property (p_locked_ignored) else $error("locked write changed reg");

  property p_blank_on_write;
    @(posedge clk_sys) disable iff (rst) (wr_one || wr_two) |=> monitor_blank [*8];
  endproperty
  a_blank_on_write: assert property (p_blank_on_write) else $error("no blanking after write");

  property p_no_apply_hold;
    @(posedge clk_sys) disable iff (rst)
      !(apply_go || apply_bypass) |=> $stable(buck_one_code) && $stable(buck_two_code);
  endproperty
  a_no_apply_hold: assert property (p_no_apply_hold) else $error("code moved without apply");

  property p_apply_takes;
    @(posedge clk_sys) disable iff (rst)
      (apply_go || apply_bypass) |=> buck_two_code == $past(state.two_reg.code);
  endproperty
  a_apply_takes: assert property (p_apply_takes) else $error("apply did not take code");

  property p_skip_follow;
    @(posedge clk_sys) disable iff (rst)
      wr_one |=> buck_one_skip_en == $past(host_wreq.data[BVS_SKIP_BIT]);
  endproperty
  a_skip_follow: assert property (p_skip_follow) else $error("skip bit not taken");

  property p_rsvd_zero;
    @(posedge clk_sys) disable iff (rst) host_rdata[BVS_RSVD_BIT] == 1'b0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit reads one");

  property p_read_one;
    @(posedge clk_sys) disable iff (rst)
      (host_raddr == BVS_OFS_BUCK_ONE) |=> host_rdata[5:0] == $past(state.one_reg.code);
  endproperty
  a_read_one: assert property (p_read_one) else $error("first register read wrong");

  property p_mv_map;
    @(posedge clk_sys) disable iff (rst)
      (buck_one_code == 6'h3F) |-> buck_one_mv == 11'h68B;
  endproperty
  a_mv_map: assert property (p_mv_map) else $error("top code not 1675 mV");

  property p_mv_two;
    @(posedge clk_sys) disable iff (rst)
      (buck_two_code == 6'h23) |-> buck_two_mv == 11'h4B0;
  endproperty
  a_mv_two: assert property (p_mv_two) else $error("code 23h not 1200 mV");

  property p_apply_one;
    @(posedge clk_sys) disable iff (rst)
      (apply_go || apply_bypass) |=> buck_one_code == $past(state.one_reg.code);
  endproperty
  a_apply_one: assert property (p_apply_one) else $error("apply did not take first code");

  property p_skip_two;
    @(posedge clk_sys) disable iff (rst)
      wr_two |=> buck_two_skip_en == $past(host_wreq.data[BVS_SKIP_BIT]);
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("second skip bit not taken");

  // Code field and skip bit of the second register; bit 6 is not compared here
  property p_read_two;
    @(posedge clk_sys) disable iff (rst)
      (host_raddr == BVS_OFS_BUCK_TWO) |=>
        host_rdata[5:0] == $past(state.two_reg.code) && host_rdata[7] == $past(state.two_reg.skip_en);
  endproperty
  a_read_two: assert property (p_read_two) else $error("second register read wrong");

endmodule : bvs_regs
`default_nettype wire

// [sim/bvs_regs_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module bvs_regs_bench
  import bvs_pkg::*;
;
  // Short blanking span keeps the run brief
  localparam int BLANK = 20;
  logic        clk_sys = 1'b0;
  logic        rst;
  bvs_wreq_t   host_wreq;
  logic [7:0]  host_raddr;
  logic        unlocked;
  logic        apply_go;
  logic        apply_bypass;
  logic [7:0]  host_rdata;
  logic        s1_skip, s2_skip;
  logic [5:0]  s1_code, s2_code;
  logic [10:0] s1_mv, s2_mv;
  logic        monitor_blank;
  logic [7:0]  m_s1, m_s2, m_rd;
  logic [5:0]  m_a1, m_a2;
  logic [15:0] lfsr_st;
  int          m_cnt;
  int          num_errors;
  int          n_tests;

  always #2 clk_sys = ~clk_sys;

  bvs_regs #(.BLANK_CYCLES(BLANK)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .host_wreq(host_wreq), .host_raddr(host_raddr),
    .unlocked(unlocked), .apply_go(apply_go), .apply_bypass(apply_bypass),
    .host_rdata(host_rdata), .buck_one_skip_en(s1_skip), .buck_one_code(s1_code),
    .buck_one_mv(s1_mv), .buck_two_skip_en(s2_skip), .buck_two_code(s2_code),
    .buck_two_mv(s2_mv), .monitor_blank(monitor_blank));

  ////////////////////////////////////////////////////////////////////////////////
  // Millivolt map: fine steps up to the knee, coarse above
  function automatic logic [10:0] mv_of(input logic [5:0] c);
    int v;
    v = (c <= 6'h32) ? 850 + 10 * c : 1350 + 25 * (c - 6'h32);
    return v[10:0];
  endfunction : mv_of

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // Reference model; apply copies the stored code from before this edge's write
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      m_s1 = BVS_SETTING_RST;
      m_s2 = BVS_SETTING_RST;
      m_a1 = BVS_CODE_RST;
      m_a2 = BVS_CODE_RST;
      m_rd = 8'h00;
      m_cnt = 0;
    end else begin
      m_rd = (host_raddr == 8'h16) ? m_s1 : (host_raddr == 8'h17) ? m_s2 : 8'h00;
      if (apply_go || apply_bypass) begin
        m_a1 = m_s1[5:0];
        m_a2 = m_s2[5:0];
      end
      if (m_cnt > 0) m_cnt = m_cnt - 1;
      if (host_wreq.wr && unlocked && host_wreq.addr == 8'h16) m_s1 = host_wreq.data & 8'hBF;
      if (host_wreq.wr && unlocked && host_wreq.addr == 8'h17) m_s2 = host_wreq.data & 8'hBF;
      if (host_wreq.wr && unlocked && (host_wreq.addr == 8'h16 || host_wreq.addr == 8'h17))
        m_cnt = BLANK + 1;
    end
  end

  task automatic check(input logic [10:0] got, input logic [10:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Outputs settle at the rising edge, so the falling edge sees them steady
  always @(negedge clk_sys) begin
    if (!rst) begin
      check(11'(host_rdata), 11'(m_rd));
      check(11'(s1_skip), 11'(m_s1[7]));
      check(11'(s1_code), 11'(m_a1));
      check(s1_mv, mv_of(m_a1));
      check(11'(s2_skip), 11'(m_s2[7]));
      check(11'(s2_code), 11'(m_a2));
      check(s2_mv, mv_of(m_a2));
      check(11'(monitor_blank), 11'(m_cnt != 0));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One cycle of host activity, launched at the falling edge
  task automatic drv(input logic w, input logic [7:0] a, input logic [7:0] d, input logic u,
                     input logic g, input logic b, input logic [7:0] ra);
    @(negedge clk_sys);
    host_wreq = '{wr: w, addr: a, data: d};
    unlocked = u;
    apply_go = g;
    apply_bypass = b;
    host_raddr = ra;
  endtask : drv

  task automatic idle(input int n, input logic [7:0] ra);
    repeat (n) drv(1'b0, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0, ra);
  endtask : idle

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // Hang guard: several times the roughly 900 cycles of stimulus
  initial begin
    #(4 * 6000);
    num_errors++;
    stop_test;
  end

  initial begin
    host_wreq = '0;
    host_raddr = 8'h00;
    unlocked = 1'b0;
    apply_go = 1'b0;
    apply_bypass = 1'b0;
    rst = 1'b1;
    num_errors = 0;
    n_tests = 0;
    lfsr_st = 16'h0035;
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    idle(2, 8'h17);
    // Locked writes must change nothing, even with apply in the same cycle
    drv(1'b1, 8'h16, 8'h05, 1'b0, 1'b0, 1'b0, 8'h16);
    drv(1'b1, 8'h17, 8'h05, 1'b0, 1'b1, 1'b0, 8'h17);
    idle(3, 8'h1A);
    // Reserved bit written high, apply in the same cycle as the write
    drv(1'b1, 8'h16, 8'h7F, 1'b1, 1'b1, 1'b0, 8'h16);
    idle(4, 8'h16);
    drv(1'b0, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 8'h16);
    // Second write in the span restarts blanking
    drv(1'b1, 8'h17, 8'hC0, 1'b1, 1'b0, 1'b0, 8'h17);
    idle(8, 8'h17);
    drv(1'b1, 8'h17, 8'h3F, 1'b1, 1'b0, 1'b0, 8'h17);
    idle(BLANK + 4, 8'h15);
    // Sweep every code through both converters
    for (int i = 0; i < 64; i++) begin
      lfsr_st = lfsr_next(lfsr_st);
      drv(1'b1, 8'h16 + i[0], {lfsr_st[1:0], i[5:0]}, 1'b1, 1'b0, 1'b0, 8'h16);
      drv(1'b1, 8'h17 - i[0], {lfsr_st[3:2], i[5:0]}, 1'b1, 1'b0, 1'b0, 8'h17);
      drv(1'b0, 8'h00, 8'h00, 1'b0, lfsr_st[4], ~lfsr_st[4], 8'h16);
    end
    // Reset in mid-run restores defaults and stops blanking
    drv(1'b1, 8'h16, 8'h01, 1'b1, 1'b0, 1'b0, 8'h16);
    rst = 1'b1;
    idle(2, 8'h16);
    rst = 1'b0;
    idle(3, 8'h16);
    // Random traffic over mapped and unmapped places
    for (int i = 0; i < 600; i++) begin
      lfsr_st = lfsr_next(lfsr_st);
      drv(lfsr_st[2], 8'h15 + lfsr_st[1:0], lfsr_st[15:8], lfsr_st[3] | lfsr_st[4],
          lfsr_st[5] & lfsr_st[6], lfsr_st[7] & lfsr_st[0], 8'h15 + lfsr_st[10:9]);
    end
    idle(BLANK + 4, 8'h00);
    stop_test;
  end
endmodule : bvs_regs_bench
`default_nettype wire
